// ===== rtl/mbrs_pkg.sv
package mbrs_pkg;

  // Character: start, eight data, parity or stop, stop.
  localparam int CHAR_BITS  = 11;
  localparam int HB_PER_BIT = 2;
  localparam logic [2:0] DATA_LAST_BIT = 3'h7;
  localparam logic [3:0] CHAR_LAST_BIT = 4'(CHAR_BITS - 1);

  // Silent intervals in tenths of a character time.
  localparam int GAP_END_X10   = 35;
  localparam int GAP_FLUSH_X10 = 15;

  // The same in receiver half-bit ticks.
  localparam int GAP_W = 7;
  localparam logic [GAP_W-1:0] GAP_END_HB   = GAP_W'((CHAR_BITS * HB_PER_BIT * GAP_END_X10 + 9) / 10);
  localparam logic [GAP_W-1:0] GAP_FLUSH_HB = GAP_W'(CHAR_BITS * HB_PER_BIT * GAP_FLUSH_X10 / 10);
  localparam logic [GAP_W-1:0] GAP_MAX      = {GAP_W{1'b1}};

  // Parity selection codes; any other code means no parity.
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;

  // Slave address field values.
  localparam logic [7:0] ADDR_BCAST = 8'h00;
  localparam logic [7:0] ADDR_MIN   = 8'h01;
  localparam logic [7:0] ADDR_MAX   = 8'hF7;

  // Function codes of the supported set.
  localparam logic [7:0] FC_READ_COILS   = 8'h01;
  localparam logic [7:0] FC_READ_HOLD    = 8'h03;
  localparam logic [7:0] FC_READ_INPUT   = 8'h04;
  localparam logic [7:0] FC_FORCE_COIL   = 8'h05;
  localparam logic [7:0] FC_PRESET_REG   = 8'h06;
  localparam logic [7:0] FC_RESET_SLAVE  = 8'h08;
  localparam logic [7:0] FC_FORCE_COILS  = 8'h0F;
  localparam logic [7:0] FC_PRESET_REGS  = 8'h10;
  localparam logic [7:0] FC_REPORT_ID    = 8'h11;
  localparam logic [7:0] FC_EXC_FLAG     = 8'h80;

  // Exception reason codes.
  localparam logic [7:0] EXC_ILL_FUNC  = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR  = 8'h02;
  localparam logic [7:0] EXC_ILL_VALUE = 8'h03;

  // Coil read geometry and frame lengths in bytes.
  localparam logic [16:0] COIL_COUNT    = 17'h00004;
  localparam logic [7:0]  RC_BYTE_COUNT = 8'h01;
  localparam logic [7:0]  RC_REQ_LEN    = 8'h08;
  localparam logic [7:0]  MIN_FRAME_LEN = 8'h04;
  localparam logic [2:0]  RESP_LEN_COIL = 3'h6;
  localparam logic [2:0]  RESP_LEN_EXC  = 3'h5;
  localparam logic [2:0]  IDX_ADDR      = 3'h0;
  localparam logic [2:0]  IDX_FUNC      = 3'h1;
  localparam logic [2:0]  IDX_DATA0     = 3'h2;
  localparam logic [2:0]  CRC_BYTES     = 3'h2;

  // Check field parameters.
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  // Advance the reflected check by one byte, low bit first.
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // Parity bit of a byte; idle level when parity is off.
  function automatic logic parity_bit(input logic [1:0] mode, input logic [7:0] data);
    if (mode == PAR_EVEN) begin
      return ^data;
    end else if (mode == PAR_ODD) begin
      return ~^data;
    end
    return 1'b1;
  endfunction

  // True for every function code this slave answers.
  function automatic logic fc_supported(input logic [7:0] fc);
    return fc inside {FC_READ_COILS, FC_READ_HOLD, FC_READ_INPUT, FC_FORCE_COIL,
                      FC_PRESET_REG, FC_RESET_SLAVE, FC_FORCE_COILS, FC_PRESET_REGS,
                      FC_REPORT_ID};
  endfunction

endpackage

// ===== rtl/mbrs_char_if.sv
`timescale 1ns/1ns
// Characters from the serial receiver to the frame logic.
interface mbrs_char_if;
  logic [15:0] half_div;    // Clock cycles per half bit.
  logic [1:0]  parity_mode; // Parity selection code.
  logic        hb_tick;     // Half-bit enable pulse.
  logic        rx_idle;     // Receiver waits for a start bit.
  logic        char_valid;  // One-cycle pulse with a new character.
  logic        char_err;    // Parity or framing fault on that character.
  logic [7:0]  char_data;   // Received character.
  modport rx (input half_div, input parity_mode, output hb_tick, output rx_idle,
              output char_valid, output char_err, output char_data);
  modport fr (output half_div, output parity_mode, input hb_tick, input rx_idle,
              input char_valid, input char_err, input char_data);
endinterface

// ===== rtl/mbrs_uart_rx.sv
`timescale 1ns/1ns
module mbrs_uart_rx (
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic resetn,
  // Serial line from the transceiver.
  input  wire logic rx_pin,
  // Characters to the frame logic.
  mbrs_char_if.rx   chr
);
  import mbrs_pkg::*;

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} mbrs_rx_state_t;

  mbrs_rx_state_t state_reg;   // Receiver sequence.
  logic           sync1_reg;   // First synchroniser stage.
  logic           sync2_reg;   // Second synchroniser stage.
  logic           prev_reg;    // Delayed line for edge search.
  logic [15:0]    hb_cnt_reg;  // Half-bit cycle counter.
  logic           phase_reg;   // High on the bit-centre half tick.
  logic [2:0]     bitn_reg;    // Data bit index.
  logic [7:0]     shift_reg;   // Data shifter, filled from the top.
  logic           perr_reg;    // Parity fault of the current character.
  logic           start_edge;  // Falling line while idle.

  assign start_edge  = (state_reg == RX_IDLE) && prev_reg && !sync2_reg;
  assign chr.hb_tick = (hb_cnt_reg == 16'(chr.half_div - 16'h0001));
  assign chr.rx_idle = (state_reg == RX_IDLE);

  // The line is asynchronous, so it passes two stages first.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg  <= 1'b1;
    end else begin
      sync1_reg <= rx_pin;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // The half-bit timer restarts on a start edge to sample mid-bit.
  always_ff @(posedge ref_clk) begin
    if (!resetn || start_edge || chr.hb_tick) begin
      hb_cnt_reg <= 16'h0000;
    end else begin
      hb_cnt_reg <= hb_cnt_reg + 16'h0001;
    end
  end

  // Leaving at mid stop lets a second stop bit pass as idle.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_reg      <= RX_IDLE;
      phase_reg      <= 1'b0;
      bitn_reg       <= 3'h0;
      shift_reg      <= 8'h00;
      perr_reg       <= 1'b0;
      chr.char_valid <= 1'b0;
      chr.char_err   <= 1'b0;
      chr.char_data  <= 8'h00;
    end else begin
      chr.char_valid <= 1'b0;
      unique case (state_reg)
        RX_IDLE: begin
          if (start_edge) begin
            state_reg <= RX_START;
          end
        end
        // R06 start bit check
        RX_START: begin
          if (chr.hb_tick) begin
            state_reg <= sync2_reg ? RX_IDLE : RX_DATA;
            phase_reg <= 1'b0;
            bitn_reg  <= 3'h0;
            perr_reg  <= 1'b0;
          end
        end
        // R06 LSB first shift
        RX_DATA: begin
          if (chr.hb_tick) begin
            phase_reg <= !phase_reg;
            if (phase_reg) begin
              shift_reg <= {sync2_reg, shift_reg[7:1]};
              bitn_reg  <= bitn_reg + 3'h1;
              if (bitn_reg == DATA_LAST_BIT) begin
                state_reg <= (parity_bit(chr.parity_mode, 8'h00) == 1'b1 &&
                              chr.parity_mode != PAR_ODD) ? RX_STOP : RX_PAR;
              end
            end
          end
        end
        // R08 parity bit check
        RX_PAR: begin
          if (chr.hb_tick) begin
            phase_reg <= !phase_reg;
            if (phase_reg) begin
              perr_reg  <= (sync2_reg != parity_bit(chr.parity_mode, shift_reg));
              state_reg <= RX_STOP;
            end
          end
        end
        // R07 one stop bit suffices
        RX_STOP: begin
          if (chr.hb_tick) begin
            phase_reg <= !phase_reg;
            if (phase_reg) begin
              chr.char_valid <= 1'b1;
              chr.char_err   <= perr_reg || !sync2_reg;
              chr.char_data  <= shift_reg;
              state_reg      <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end

endmodule

// ===== rtl/mbrs_framer.sv
`timescale 1ns/1ns
// Operation
// R01 - Frame starts after 3.5 idle characters; after a flushed frame, a gap over 1.5 characters suffices
// R02 - Address, function, data, then 16-bit check
// R03 - 3.5 idle characters end the frame
// R04 - Gap over 1.5 characters flushes partial frame
// R05 - Early bytes append; combined frame fails
// R06 - Start, eight data LSB first, then stop
// R07 - No parity accepts one or two stops
// R08 - Even, odd or none; parity uses one stop
// R09 - Accept own address 1-247 only
// R10 - Responses carry own slave address
// R11 - Address zero is broadcast, never answered
// R12 - Data item addresses are zero based
// R13 - Only nine listed function codes
// R14 - Normal response echoes function code
// R15 - Exception sets bit 7, adds reason
// R16 - Master handles exception responses
// R17 - Coil read: no broadcast, coils 0-3
// R18 - Coil bit one means output driven on
// R19 - Coil bits packed from LSB, rest zero
// R20 - Unsupported broadcast functions are ignored
// R21 - Standard CRC, low byte first, failures dropped
// R22 - Coil reply: address, function, count, data, check
module mbrs_framer (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Serial line pins of the half-duplex transceiver.
  input  wire logic        rx_pin,
  output logic             tx_pin,
  output logic             tx_oe,
  // Static configuration.
  input  wire logic [7:0]  slave_addr,
  input  wire logic [1:0]  parity_mode,
  input  wire logic [15:0] half_div,
  // Gate levels of the four output drivers.
  input  wire logic [3:0]  coil_gate,
  // Hand-off of accepted requests to the other function handlers.
  output logic             req_valid,
  output logic [7:0]       req_func,
  output logic             req_bcast,
  // Dropped frame pulse, for diagnostics.
  output logic             frame_drop
);
  import mbrs_pkg::*;

  typedef enum logic [2:0] {FR_SYNC, FR_IDLE, FR_BODY, FR_HOLD} mbrs_fr_state_t;

  mbrs_char_if chr ();

  // Receive side state.
  mbrs_fr_state_t   fr_state_reg;  // Frame delimiting sequence.
  logic [GAP_W-1:0] gap_reg;       // Silent half bits since the last character.
  logic [15:0]      rcrc_reg;      // Running check over every byte of the frame.
  logic [7:0]       len_reg;       // Bytes in the frame, saturating.
  logic             bad_reg;       // A character of this frame was faulty.
  logic [7:0]       addr_reg;      // Address field.
  logic [7:0]       func_reg;      // Function field.
  logic [7:0]       d0_reg;        // First four data bytes.
  logic [7:0]       d1_reg;
  logic [7:0]       d2_reg;
  logic [7:0]       d3_reg;

  // Response side state.
  logic             rsp_exc_reg;   // Response is an exception.
  logic [7:0]       rsp_code_reg;  // Exception reason or coil status byte.
  logic [7:0]       rsp_func_reg;  // Function of the answered request.
  logic [2:0]       rsp_len_reg;   // Response length in bytes.
  logic             tx_busy_reg;   // Serialiser active.
  logic [2:0]       tx_idx_reg;    // Index of the next byte to load.
  logic [10:0]      tx_shift_reg;  // Character being sent, low bit first.
  logic [3:0]       tx_bitn_reg;   // Bits already sent of this character.
  logic [16:0]      tx_cnt_reg;    // Cycles within the current bit.
  logic [15:0]      tx_crc_reg;    // Running check over sent bytes.

  // Combinational decode.
  logic             gap_flush;     // Gap longer than the flush interval.
  logic             gap_end;       // Gap reached the end interval.
  logic             is_bcast;      // Frame addressed to everybody.
  logic             is_mine;       // Frame addressed to this slave.
  logic             deliver;       // Complete, checked, addressed frame.
  logic [16:0]      rc_start;      // First coil requested.
  logic [16:0]      rc_qty;        // Number of coils requested.
  logic [7:0]       rc_bits;       // Packed coil status byte.
  logic             start_rsp;     // Launch a response.
  logic             rsp_exc_next;  // Kind of the response to launch.
  logic [7:0]       rsp_code_next; // Reason or status of that response.
  logic [7:0]       tx_byte;       // Byte at the current send index.
  logic             bit_end;       // Last cycle of a sent bit.

  assign chr.half_div    = half_div;
  assign chr.parity_mode = parity_mode;

  // The receiver's half-bit tick also drives the gap timer.
  mbrs_uart_rx u_rx (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .rx_pin  (rx_pin),
    .chr     (chr)
  );

  assign gap_flush = (gap_reg > GAP_FLUSH_HB);
  assign gap_end   = (gap_reg >= GAP_END_HB);

  // Silence counts half bits while the receiver idles;
  // line activity clears it, so a partial character is no silence.
  always_ff @(posedge ref_clk) begin
    if (!resetn || !chr.rx_idle || chr.char_valid) begin
      gap_reg <= '0;
    end else if (chr.hb_tick && gap_reg != GAP_MAX) begin
      gap_reg <= gap_reg + GAP_W'(1);
    end
  end

  // R09 own address window
  assign is_mine  = (addr_reg == slave_addr) && (slave_addr >= ADDR_MIN) &&
                    (slave_addr <= ADDR_MAX);
  // R11 broadcast address
  assign is_bcast = (addr_reg == ADDR_BCAST);
  // R03 end by silence
  assign deliver  = (fr_state_reg == FR_HOLD) && gap_end && (is_mine || is_bcast);

  // Delimiting. A flush-length gap ends the body; a good body then
  // waits for the end gap, where a late byte still joins it.
  // A failing body is flushed at once.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fr_state_reg <= FR_SYNC;
      frame_drop   <= 1'b0;
    end else begin
      frame_drop <= 1'b0;
      unique case (fr_state_reg)
        // R01 initial silence
        FR_SYNC: begin
          if (gap_end) begin
            fr_state_reg <= FR_IDLE;
          end
        end
        FR_IDLE: begin
          if (chr.char_valid) begin
            fr_state_reg <= FR_BODY;
          end
        end
        FR_BODY: begin
          // R04 flush partial frame
          if (gap_flush) begin
            if (!bad_reg && rcrc_reg == 16'h0000 && len_reg >= MIN_FRAME_LEN) begin
              fr_state_reg <= FR_HOLD;
            end else begin
              fr_state_reg <= FR_IDLE;
              frame_drop   <= 1'b1;
            end
          end
        end
        FR_HOLD: begin
          // R05 early byte appends
          if (chr.char_valid) begin
            fr_state_reg <= FR_BODY;
          end else if (gap_end) begin
            fr_state_reg <= FR_IDLE;
          end
        end
      endcase
    end
  end

  // Capture and running check. The first byte after idle is the
  // address; the check field is folded in too, so a good frame
  // leaves zero.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rcrc_reg <= CRC_INIT;
      len_reg  <= 8'h00;
      bad_reg  <= 1'b0;
      addr_reg <= 8'h00;
      func_reg <= 8'h00;
      d0_reg   <= 8'h00;
      d1_reg   <= 8'h00;
      d2_reg   <= 8'h00;
      d3_reg   <= 8'h00;
    end else if (chr.char_valid) begin
      // R02 field order
      if (fr_state_reg == FR_IDLE || fr_state_reg == FR_SYNC) begin
        rcrc_reg <= crc_byte(CRC_INIT, chr.char_data);
        len_reg  <= 8'h01;
        bad_reg  <= chr.char_err;
        addr_reg <= chr.char_data;
      end else begin
        // R21 running check
        rcrc_reg <= crc_byte(rcrc_reg, chr.char_data);
        bad_reg  <= bad_reg || chr.char_err;
        if (len_reg != 8'hFF) begin
          len_reg <= len_reg + 8'h01;
        end
        unique case (len_reg)
          8'h01:   func_reg <= chr.char_data;
          8'h02:   d0_reg   <= chr.char_data;
          8'h03:   d1_reg   <= chr.char_data;
          8'h04:   d2_reg   <= chr.char_data;
          8'h05:   d3_reg   <= chr.char_data;
          default: ;
        endcase
      end
    end
  end

  // R12 zero-based coil numbers
  assign rc_start = {1'b0, d0_reg, d1_reg};
  assign rc_qty   = {1'b0, d2_reg, d3_reg};

  // R18 gate level is status
  // R19 pack from LSB
  always_comb begin
    rc_bits = 8'h00;
    for (int i = 0; i < 4; i++) begin
      if (17'(i) < rc_qty && rc_start + 17'(i) < COIL_COUNT) begin
        rc_bits[i] = coil_gate[2'(rc_start + 17'(i))];
      end
    end
  end

  // Reply decision at frame end. Broadcast never gets a reply;
  // other supported functions go to the outside handlers.
  always_comb begin
    start_rsp     = 1'b0;
    rsp_exc_next  = 1'b0;
    rsp_code_next = 8'h00;
    if (deliver && !is_bcast && !tx_busy_reg) begin
      // R13 supported set
      if (!fc_supported(func_reg)) begin
        start_rsp     = 1'b1;
        rsp_exc_next  = 1'b1;
        rsp_code_next = EXC_ILL_FUNC;
      end else if (func_reg == FC_READ_COILS) begin
        start_rsp = 1'b1;
        // R17 coil range check
        if (len_reg != RC_REQ_LEN || rc_qty == 17'h00000 || rc_qty > COIL_COUNT) begin
          rsp_exc_next  = 1'b1;
          rsp_code_next = EXC_ILL_VALUE;
        end else if (rc_start + rc_qty > COIL_COUNT) begin
          rsp_exc_next  = 1'b1;
          rsp_code_next = EXC_ILL_ADDR;
        end else begin
          rsp_code_next = rc_bits;
        end
      end
    end
  end

  // Hand-off to other handlers; broadcast coil reads do nothing.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      req_valid <= 1'b0;
      req_func  <= 8'h00;
      req_bcast <= 1'b0;
    end else begin
      // R20 broadcast filter
      req_valid <= deliver && fc_supported(func_reg) && func_reg != FC_READ_COILS &&
                   (is_bcast || !tx_busy_reg);
      if (deliver) begin
        req_func  <= func_reg;
        req_bcast <= is_bcast;
      end
    end
  end

  // Latch the reply so later frames cannot disturb it.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rsp_exc_reg  <= 1'b0;
      rsp_code_reg <= 8'h00;
      rsp_func_reg <= 8'h00;
      rsp_len_reg  <= RESP_LEN_EXC;
    end else if (start_rsp) begin
      rsp_exc_reg  <= rsp_exc_next;
      rsp_code_reg <= rsp_code_next;
      rsp_func_reg <= func_reg;
      // R22 coil reply length
      rsp_len_reg  <= rsp_exc_next ? RESP_LEN_EXC : RESP_LEN_COIL;
    end
  end

  // Byte at the current send index.
  always_comb begin
    tx_byte = 8'h00;
    if (tx_idx_reg == IDX_ADDR) begin
      // R10 own address
      tx_byte = slave_addr;
    end else if (tx_idx_reg == IDX_FUNC) begin
      // R14 echo function
      // R15 exception flag
      tx_byte = rsp_exc_reg ? (rsp_func_reg | FC_EXC_FLAG) : rsp_func_reg;
    end else if (tx_idx_reg == IDX_DATA0) begin
      tx_byte = rsp_exc_reg ? rsp_code_reg : RC_BYTE_COUNT;
    end else if (tx_idx_reg == rsp_len_reg - CRC_BYTES) begin
      // R21 check low byte first
      tx_byte = tx_crc_reg[7:0];
    end else if (tx_idx_reg == rsp_len_reg - 3'h1) begin
      tx_byte = tx_crc_reg[15:8];
    end else begin
      tx_byte = rsp_code_reg;
    end
  end

  assign bit_end = (tx_cnt_reg == 17'({half_div, 1'b0} - 17'h00001));

  // Serialiser: start, data, parity or first stop, then stop;
  // without parity two stops always go out.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      tx_busy_reg  <= 1'b0;
      tx_idx_reg   <= 3'h0;
      tx_shift_reg <= {CHAR_BITS{1'b1}};
      tx_bitn_reg  <= 4'h0;
      tx_cnt_reg   <= 17'h00000;
      tx_crc_reg   <= CRC_INIT;
      tx_pin       <= 1'b1;
      tx_oe        <= 1'b0;
    end else if (!tx_busy_reg) begin
      tx_pin <= 1'b1;
      tx_oe  <= 1'b0;
      if (start_rsp) begin
        tx_busy_reg <= 1'b1;
        tx_idx_reg  <= IDX_ADDR;
        tx_bitn_reg <= CHAR_LAST_BIT;
        tx_cnt_reg  <= 17'({half_div, 1'b0} - 17'h00001);
        tx_crc_reg  <= CRC_INIT;
      end
    end else begin
      tx_oe      <= 1'b1;
      tx_cnt_reg <= bit_end ? 17'h00000 : tx_cnt_reg + 17'h00001;
      if (bit_end) begin
        if (tx_bitn_reg == CHAR_LAST_BIT) begin
          if (tx_idx_reg == rsp_len_reg) begin
            tx_busy_reg <= 1'b0;
            tx_pin      <= 1'b1;
          end else begin
            // R06 LSB first framing
            // R08 parity or stop
            tx_shift_reg <= {1'b1, parity_bit(parity_mode, tx_byte), tx_byte, 1'b0};
            tx_pin       <= 1'b0;
            tx_bitn_reg  <= 4'h0;
            tx_idx_reg   <= tx_idx_reg + 3'h1;
            if (tx_idx_reg < rsp_len_reg - CRC_BYTES) begin
              tx_crc_reg <= crc_byte(tx_crc_reg, tx_byte);
            end
          end
        end else begin
          tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
          tx_pin       <= tx_shift_reg[1];
          tx_bitn_reg  <= tx_bitn_reg + 4'h1;
        end
      end
    end
  end

endmodule

// ===== test/mbrs_framer_checker.sv
`timescale 1ns/1ns
// Watches the framer's pins; bit timing assumes half_div of four.
module mbrs_framer_checker (
  // Clock and reset.
  input wire logic       ref_clk,
  input wire logic       resetn,
  // Transmit side and request hand-off.
  input wire logic       tx_pin,
  input wire logic       tx_oe,
  input wire logic       req_valid,
  input wire logic [7:0] req_func,
  input wire logic       req_bcast,
  input wire logic       frame_drop
);
  import mbrs_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  line_idle_a: assert property (!tx_oe && !$past(tx_oe) |-> tx_pin)
    else $error("line low while driver off");
  bit_hold_a: assert property ($changed(tx_pin) |=> $stable(tx_pin) [*7])
    else $error("bit shorter than eight cycles");
  start_bit_a: assert property ($rose(tx_oe) |-> ##[0:2] !tx_pin)
    else $error("reply without start bit");
  req_pulse_a: assert property (req_valid |=> !req_valid)
    else $error("request pulse too long");
  req_code_a: assert property (req_valid |-> fc_supported(req_func) && req_func != 8'h01)
    else $error("bad code handed off");
  bcast_quiet_a: assert property (req_valid && req_bcast |-> !$rose(tx_oe) [*3])
    else $error("broadcast answered");
  drop_noreq_a: assert property (frame_drop |-> !req_valid)
    else $error("dropped frame handed off");
  drop_pulse_a: assert property (frame_drop |=> !frame_drop)
    else $error("drop pulse too long");
endmodule
bind mbrs_framer mbrs_framer_checker i_chk (.ref_clk(ref_clk), .resetn(resetn),
  .tx_pin(tx_pin), .tx_oe(tx_oe), .req_valid(req_valid), .req_func(req_func),
  .req_bcast(req_bcast), .frame_drop(frame_drop));

// ===== test/mbrs_master_model.sv
`timescale 1ns/1ns
// Host: sends requests, decodes replies, even parity.
module mbrs_master_model (
  // Clock.
  input wire logic  ref_clk,
  // Serial lines.
  output logic      rx_pin,
  input wire logic  tx_pin,
  input wire logic  tx_oe,
  // Reply characters; a parity or stop fault inverts the byte.
  output logic [7:0] got_byte,
  output logic       got_stb
);
  logic [9:0] r; // Sampled data, parity and stop bits.
  initial begin
    rx_pin = 1'b1;
    got_byte = 8'h00;
    got_stb = 1'b0;
  end
  // start, data LSB first, even parity, stop
  task automatic send_char(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_pin <= f[i];
      repeat (8) @(negedge ref_clk);
    end
  endtask
  // decode each reply character at mid bit
  always @(negedge ref_clk) begin
    got_stb <= 1'b0;
    if (tx_oe && !tx_pin) begin
      repeat (4) @(negedge ref_clk);
      for (int i = 0; i < 10; i++) begin
        repeat (8) @(negedge ref_clk);
        r[i] = tx_pin;
      end
      got_byte <= r[7:0] ^ {8{(r[8] != ^r[7:0]) || !r[9]}};
      got_stb <= 1'b1;
    end
  end
endmodule

// ===== test/mbrs_framer_tb.sv
`timescale 1ns/1ns
module mbrs_framer_tb;
  import mbrs_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn, rx_pin, tx_pin, tx_oe, req_valid, req_bcast, frame_drop, got_stb;
  logic [3:0] coil_gate;
  logic [7:0] slave_addr, req_func, got_byte;
  logic [9:0] exp_q[$]; // Notes: 0xx reply byte, 2xx or 3xx hand-off, 100 drop.
  logic [7:0] fq[$];    // Frame under construction.
  logic [7:0] sup[8] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h0F, 8'h10, 8'h11};
  int num_errors = 0;
  int n_compared = 0;
  int seed = 47;
  always #5 ref_clk = ~ref_clk;
  mbrs_framer i_mbrs_framer (.ref_clk(ref_clk), .resetn(resetn), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .tx_oe(tx_oe), .slave_addr(slave_addr), .parity_mode(PAR_EVEN),
    .half_div(16'h0004), .coil_gate(coil_gate), .req_valid(req_valid),
    .req_func(req_func), .req_bcast(req_bcast), .frame_drop(frame_drop));
  mbrs_master_model i_mbrs_master_model (.ref_clk(ref_clk), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .tx_oe(tx_oe), .got_byte(got_byte), .got_stb(got_stb));
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[k]) begin
      c ^= {8'h00, q[k]};
      for (int i = 0; i < 8; i++)
        c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  // frame then check field, low byte first
  task automatic send_f(input int gap, input bit crc);
    logic [15:0] c;
    c = crc16(fq);
    if (crc) fq = {fq, c[7:0], c[15:8]};
    foreach (fq[k]) i_mbrs_master_model.send_char(fq[k]);
    repeat (gap) @(negedge ref_clk);
  endtask
  // Notes the reply in fq plus check.
  task automatic expect_tx();
    logic [15:0] c;
    c = crc16(fq);
    fq = {fq, c[7:0], c[15:8]};
    foreach (fq[k]) exp_q.push_back({2'h0, fq[k]});
  endtask
  // Coil read of n from st; ex is the reason, zero on success.
  task automatic coil_rd(input logic [7:0] st, input logic [7:0] n, input logic [7:0] ex);
    logic [7:0] s;
    s = 8'((coil_gate >> st) & ~(4'hF << n));
    if (ex == 8'h00) fq = '{slave_addr, 8'h01, 8'h01, s};
    else fq = '{slave_addr, 8'h81, ex};
    expect_tx();
    fq = '{slave_addr, 8'h01, 8'h00, st, 8'h00, n};
    send_f(1200, 1'b1);
  endtask
  task automatic chk(input logic [9:0] v);
    logic [9:0] e;
    e = exp_q.size() ? exp_q.pop_front() : 10'h3FF;
    n_compared++;
    if (v !== e) begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, v, e);
    end
  endtask
  task automatic end_of_test();
    num_errors += exp_q.size();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Oldest note against each result.
  always @(posedge ref_clk) begin
    if (got_stb) chk({2'h0, got_byte});
    if (req_valid) chk({1'b1, req_bcast, req_func});
    if (frame_drop) chk(10'h100);
  end
  initial begin
    #1000000;
    num_errors++;
    end_of_test();
  end
  initial begin
    resetn = 1'b0;
    coil_gate = 4'h0;
    slave_addr = 8'hF7;
    repeat (4) @(negedge ref_clk);
    resetn = 1'b1;
    // line idle before the first frame
    repeat (400) @(negedge ref_clk);
    for (int k = 0; k < 4; k++) begin
      coil_gate = 4'($random(seed));
      coil_rd(8'(k), 8'(4 - k), 8'h00);
    end
    coil_rd(8'h02, 8'h03, 8'h02);
    coil_rd(8'h00, 8'h00, 8'h03);
    coil_rd(8'h00, 8'h05, 8'h03);
    foreach (sup[k]) begin
      fq = '{slave_addr, 8'h80 | (sup[k] + 8'h01), 8'h01};
      if (!((sup[k] + 8'h01) inside {sup})) expect_tx();
      else exp_q.push_back({2'h2, sup[k] + 8'h01});
      fq = '{slave_addr, sup[k] + 8'h01, 8'h00, 8'h00, 8'h00, 8'h01};
      send_f(1200, 1'b1);
      exp_q.push_back({2'h2, sup[k]});
      fq = '{slave_addr, sup[k], 8'h00, 8'h00, 8'h00, 8'h01};
      send_f(1200, 1'b1);
    end
    // broadcast: hand-off only, coil read ignored
    exp_q.push_back({2'h3, 8'h06});
    fq = '{8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h01};
    send_f(1200, 1'b1);
    fq = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h04};
    send_f(1200, 1'b1);
    // other slave, then own address beyond 247
    fq = '{8'h05, 8'h01, 8'h00, 8'h00, 8'h00, 8'h04};
    send_f(1200, 1'b1);
    slave_addr = 8'hF8;
    fq = '{8'hF8, 8'h01, 8'h00, 8'h00, 8'h00, 8'h04};
    send_f(1200, 1'b1);
    slave_addr = 8'hF7;
    // bad check, then flush of a partial frame
    exp_q.push_back(10'h100);
    fq = '{slave_addr, 8'h01, 8'h00, 8'h00, 8'h00, 8'h04, 8'h12, 8'h34};
    send_f(1200, 1'b0);
    exp_q.push_back(10'h100);
    fq = '{slave_addr, 8'h01, 8'h00};
    send_f(160, 1'b0);
    coil_rd(8'h00, 8'h04, 8'h00);
    exp_q.push_back(10'h100);
    fq = '{slave_addr, 8'h01, 8'h00, 8'h00, 8'h00, 8'h04};
    send_f(200, 1'b1);
    fq = '{slave_addr};
    send_f(1200, 1'b0);
    end_of_test();
  end
endmodule
